// File: hw/ibgc_map.svh
// register map, field positions, reset values and timing counts of the backlight/pin controller
`ifndef IBGC_MAP_SVH
`define IBGC_MAP_SVH

// bus address of the device end (7 bits)
`define IBGC_DEV_ADDR 7'h59
`define IBGC_DIR_WRITE 1'b0
`define IBGC_DIR_READ 1'b1

// device register offsets
`define IBGC_REG_BL_CTL 8'h03
`define IBGC_REG_PRI_CODE 8'h04
`define IBGC_REG_SEC_CODE 8'h05
`define IBGC_REG_PIN_CTL 8'h06
`define IBGC_REG_PIN_DATA 8'h07

// backlight_control fields
`define IBGC_BL_RATE 5
`define IBGC_BL_SEL 4
`define IBGC_BL_FADE 3
`define IBGC_BL_SHARED 2
`define IBGC_BL_EN_PRI 1
`define IBGC_BL_EN_SEC 0
`define IBGC_BL_W 6

// pin_direction_control fields
`define IBGC_PIN_DIM 4
`define IBGC_PIN_W 3

// reset values
`define IBGC_RST_BYTE 8'h00
`define IBGC_RST_BL 6'h00
`define IBGC_RST_PIN 3'h0

// fade timing: full-scale ramp time and steps
`define IBGC_CLK_PERIOD_NS 4
`define IBGC_FADE_SLOW_NS 1300000000
`define IBGC_FADE_FAST_NS 650000000
`define IBGC_FADE_STEPS 255
`define IBGC_FADE_CNT_W 21

// controller-side registers of the host end
`define IBGC_HREG_TARGET 3'h0
`define IBGC_HREG_WDATA 3'h1
`define IBGC_HREG_GO 3'h2
`define IBGC_HREG_STATUS 3'h3
`define IBGC_HREG_RDATA 3'h4
`define IBGC_GO_WRITE 0
`define IBGC_GO_READ 1

// link clock: last count of the quarter-bit counter (10 cycles per quarter), 4 quarters per bit (160 ns period)
`define IBGC_QUARTER_CYC 4'h9
`define IBGC_BYTE_FREE 8'hff

`endif

// File: hw/ibgc_pkg.sv
// types shared by both ends of the backlight/pin controller link
`include "ibgc_map.svh"

package ibgc_pkg;

  typedef enum logic [5:0] {
    DEV_IDLE = 6'h01,
    DEV_ADDR = 6'h02,
    DEV_REG = 6'h04,
    DEV_WDATA = 6'h08,
    DEV_RDATA = 6'h10,
    DEV_SKIP = 6'h20
  } ibgc_dev_state_type;

  typedef enum logic [3:0] {
    HOST_IDLE = 4'h1,
    HOST_START = 4'h2,
    HOST_BIT = 4'h4,
    HOST_STOP = 4'h8
  } ibgc_host_state_type;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic [2:0] gpio_s1;
    logic [2:0] gpio_s2;
    ibgc_dev_state_type state;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic [7:0] tx;
    logic rw;
    logic [7:0] ptr;
    logic [`IBGC_BL_W-1:0] bl_ctl;
    logic [7:0] code_p;
    logic [7:0] code_s;
    logic [`IBGC_PIN_W-1:0] dir;
    logic dim_en;
    logic [`IBGC_PIN_W-1:0] pin_data;
    logic [7:0] act_p;
    logic [7:0] act_s;
    logic [`IBGC_FADE_CNT_W-1:0] fade_cnt;
    logic sda_oe;
    logic busy;
    logic [7:0] drive_p;
    logic [7:0] drive_s;
    logic [2:0] gpio_out;
    logic [2:0] gpio_oe;
    logic dim;
  } ibgc_dev_regs_type;

  typedef struct packed {
    logic scl;
    logic sda_oe;
    logic sda_s1;
    logic sda_s2;
    ibgc_host_state_type state;
    logic [3:0] qcnt;
    logic [1:0] q;
    logic [2:0] seq;
    logic [3:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
    logic is_read;
    logic nack;
    logic busy;
    logic [7:0] target;
    logic [7:0] wdata;
    logic [7:0] rdv;
    logic [7:0] rdata;
  } ibgc_host_regs_type;

endpackage : ibgc_pkg

// File: hw/ibgc_link_if.sv
// two-wire link between the controller end and the device end
`timescale 1ns/1ps

interface ibgc_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;

  // open-drain wire with pull-up: low whenever a driver pulls it low
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

  modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport host (output scl, output host_sda_out, output host_sda_oe, input sda);
endinterface : ibgc_link_if

// File: hw/ibgc_device.sv
// device end: two-wire slave, backlight fade logic and general purpose pins
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "ibgc_map.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE1 - fade ramps selected sink; rate bit picks time
// RULE2 - ramp time scales with size of change
// RULE3 - select bit picks primary or secondary sink
// RULE4 - fade enable bit; otherwise codes apply at once
// RULE5 - shared mode drives both sinks from primary
// RULE6 - shared mode with primary fade ramps both
// RULE7 - two enable bits switch each sink
// RULE8 - two 8-bit linear current code registers
// RULE9 - three pin direction bits, 1 is output
// RULE10 - dimming bit forces pin 0 as input
// RULE11 - dimming input exists only on pin 0
// RULE12 - output pins drive pin data bits
// RULE13 - pin data read returns sampled pin levels
// RULE14 - data line changes only while clock low
// RULE15 - detect start and stop, busy between
// RULE16 - repeated start restarts the address phase
// RULE17 - eight bits msb first plus acknowledge clock
// RULE18 - receiver pulls data low on ninth clock
// RULE19 - slave address 59h plus direction bit
// RULE20 - write sends register address then data
// RULE21 - write takes effect at final ack rise
// RULE22 - read: address write, repeated start, read
// RULE23 - foreign address: stay released, ignore transfer
// RULE24 - read byte msb first; master nacks, stops
module ibgc_device #(
  parameter int FADE_SLOW_CYC = `IBGC_FADE_SLOW_NS / (`IBGC_CLK_PERIOD_NS * `IBGC_FADE_STEPS),
  parameter int FADE_FAST_CYC = `IBGC_FADE_FAST_NS / (`IBGC_CLK_PERIOD_NS * `IBGC_FADE_STEPS)
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link to the controller
  ibgc_link_if.device link,
  // current sink codes
  output logic [7:0] primary_drive,
  output logic [7:0] secondary_drive,
  // general purpose pins
  input wire logic [2:0] gpio_in,
  output logic [2:0] gpio_out,
  output logic [2:0] gpio_oe,
  output logic dim_level,
  // link status
  output logic bus_busy
);

  ibgc_pkg::ibgc_dev_regs_type s_reg;
  ibgc_pkg::ibgc_dev_regs_type s_next;

  logic rise;
  logic fall;
  logic start_cond;
  logic stop_cond;
  logic fade_tick;
  logic [`IBGC_FADE_CNT_W-1:0] step_last;

  // one step of a ramp: moving one code per tick makes the time proportional
  function automatic logic [7:0] ibgc_toward(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt) begin
      ibgc_toward = cur + 8'h01;
    end else if (cur > tgt) begin
      ibgc_toward = cur - 8'h01;
    end else begin
      ibgc_toward = cur;
    end
  endfunction : ibgc_toward

  function automatic logic [7:0] ibgc_read(input ibgc_pkg::ibgc_dev_regs_type r);
    case (r.ptr)
      `IBGC_REG_BL_CTL: ibgc_read = {2'h0, r.bl_ctl};
      `IBGC_REG_PRI_CODE: ibgc_read = r.code_p;
      `IBGC_REG_SEC_CODE: ibgc_read = r.code_s;
      `IBGC_REG_PIN_CTL: ibgc_read = {3'h0, r.dim_en, 1'b0, r.dir};
      `IBGC_REG_PIN_DATA: ibgc_read = {5'h00, r.gpio_s2}; // RULE13
      default: ibgc_read = `IBGC_RST_BYTE;
    endcase
  endfunction : ibgc_read

  always_comb begin
    s_next = s_reg;
    s_next.scl_s1 = link.scl;
    s_next.scl_s2 = s_reg.scl_s1;
    s_next.scl_s3 = s_reg.scl_s2;
    s_next.sda_s1 = link.sda;
    s_next.sda_s2 = s_reg.sda_s1;
    s_next.sda_s3 = s_reg.sda_s2;
    s_next.gpio_s1 = gpio_in;
    s_next.gpio_s2 = s_reg.gpio_s1;
    rise = s_reg.scl_s2 & ~s_reg.scl_s3;
    fall = ~s_reg.scl_s2 & s_reg.scl_s3;
    start_cond = s_reg.scl_s2 & s_reg.scl_s3 & s_reg.sda_s3 & ~s_reg.sda_s2; // RULE15
    stop_cond = s_reg.scl_s2 & s_reg.scl_s3 & ~s_reg.sda_s3 & s_reg.sda_s2; // RULE15

    ////////////////////////////////////////////////////////////////////////////
    // link slave: sample on clock rise, change the data line only after a fall
    if (start_cond) begin
      // a repeated start lands here too and restarts the address phase
      s_next.state = ibgc_pkg::DEV_ADDR; // RULE16
      s_next.cnt = 4'h0;
      s_next.sda_oe = 1'b0;
      s_next.busy = 1'b1; // RULE15
    end else if (stop_cond) begin
      s_next.state = ibgc_pkg::DEV_IDLE;
      s_next.sda_oe = 1'b0;
      s_next.busy = 1'b0; // RULE15
    end else if (s_reg.state != ibgc_pkg::DEV_IDLE) begin
      if (rise && s_reg.cnt < 4'h8) begin
        s_next.sr = {s_reg.sr[6:0], s_reg.sda_s2}; // RULE17
        s_next.cnt = s_reg.cnt + 4'h1;
      end else if (rise) begin
        s_next.cnt = 4'h9;
        if (s_reg.state == ibgc_pkg::DEV_WDATA) begin
          // the write lands on the rise of our own acknowledge
          case (s_reg.ptr) // RULE21
            `IBGC_REG_BL_CTL: s_next.bl_ctl = s_reg.sr[`IBGC_BL_W-1:0];
            `IBGC_REG_PRI_CODE: s_next.code_p = s_reg.sr; // RULE8
            `IBGC_REG_SEC_CODE: s_next.code_s = s_reg.sr; // RULE8
            `IBGC_REG_PIN_CTL: begin
              s_next.dim_en = s_reg.sr[`IBGC_PIN_DIM];
              s_next.dir = s_reg.sr[`IBGC_PIN_W-1:0]; // RULE9
            end
            `IBGC_REG_PIN_DATA: s_next.pin_data = s_reg.sr[`IBGC_PIN_W-1:0];
            default: s_next.ptr = s_reg.ptr;
          endcase
        end else if (s_reg.state == ibgc_pkg::DEV_RDATA && s_reg.sda_s2) begin
          s_next.state = ibgc_pkg::DEV_SKIP; // RULE24
        end
      end else if (fall && s_reg.cnt == 4'h8) begin
        case (s_reg.state)
          ibgc_pkg::DEV_ADDR: begin
            if (s_reg.sr[7:1] == `IBGC_DEV_ADDR) begin // RULE19
              s_next.sda_oe = 1'b1; // RULE18
              s_next.rw = s_reg.sr[0];
            end else begin
              s_next.state = ibgc_pkg::DEV_SKIP; // RULE23
            end
          end
          ibgc_pkg::DEV_REG: s_next.sda_oe = 1'b1; // RULE18
          ibgc_pkg::DEV_WDATA: s_next.sda_oe = 1'b1; // RULE18
          ibgc_pkg::DEV_RDATA: s_next.sda_oe = 1'b0; // RULE17
          default: s_next.sda_oe = 1'b0;
        endcase
      end else if (fall && s_reg.cnt == 4'h9) begin
        s_next.cnt = 4'h0;
        s_next.sda_oe = 1'b0;
        case (s_reg.state)
          ibgc_pkg::DEV_ADDR: begin
            if (s_reg.rw == `IBGC_DIR_READ) begin
              s_next.state = ibgc_pkg::DEV_RDATA; // RULE22
              s_next.tx = ibgc_read(s_reg);
              s_next.sda_oe = ~s_next.tx[7]; // RULE24
            end else begin
              s_next.state = ibgc_pkg::DEV_REG;
            end
          end
          ibgc_pkg::DEV_REG: begin
            s_next.ptr = s_reg.sr; // RULE20
            s_next.state = ibgc_pkg::DEV_WDATA;
          end
          ibgc_pkg::DEV_RDATA: begin
            // master acknowledged: send the same register again
            s_next.tx = ibgc_read(s_reg);
            s_next.sda_oe = ~s_next.tx[7];
          end
          default: s_next.state = s_reg.state;
        endcase
      end else if (fall && s_reg.state == ibgc_pkg::DEV_RDATA && s_reg.cnt != 4'h0) begin
        s_next.sda_oe = ~s_reg.tx[3'(4'h7 - s_reg.cnt)]; // RULE14 RULE24
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fade engine: one code step per tick, step length from the rate bit
    step_last = s_reg.bl_ctl[`IBGC_BL_RATE] ? `IBGC_FADE_CNT_W'(FADE_FAST_CYC - 1)
                                              : `IBGC_FADE_CNT_W'(FADE_SLOW_CYC - 1); // RULE1
    fade_tick = s_reg.fade_cnt >= step_last;
    s_next.fade_cnt = fade_tick ? '0 : s_reg.fade_cnt + 1'b1;
    if (s_reg.bl_ctl[`IBGC_BL_FADE] && !s_reg.bl_ctl[`IBGC_BL_SEL]) begin // RULE3 RULE4
      s_next.act_p = fade_tick ? ibgc_toward(s_reg.act_p, s_reg.code_p) : s_reg.act_p; // RULE2
    end else begin
      s_next.act_p = s_reg.code_p; // RULE4
    end
    if (s_reg.bl_ctl[`IBGC_BL_FADE] && s_reg.bl_ctl[`IBGC_BL_SEL]) begin // RULE3
      s_next.act_s = fade_tick ? ibgc_toward(s_reg.act_s, s_reg.code_s) : s_reg.act_s; // RULE2
    end else begin
      s_next.act_s = s_reg.code_s;
    end
    s_next.drive_p = s_reg.bl_ctl[`IBGC_BL_EN_PRI] ? s_reg.act_p : 8'h00; // RULE7
    // in shared mode the secondary follows the primary code, ramp included
    if (!s_reg.bl_ctl[`IBGC_BL_EN_SEC]) begin
      s_next.drive_s = 8'h00; // RULE7
    end else if (s_reg.bl_ctl[`IBGC_BL_SHARED]) begin
      s_next.drive_s = s_reg.act_p; // RULE5 RULE6
    end else begin
      s_next.drive_s = s_reg.act_s; // RULE5
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins: the dimming input can take over pin 0 only
    s_next.gpio_oe = s_reg.dir & ~{2'b00, s_reg.dim_en}; // RULE9 RULE10 RULE11
    s_next.gpio_out = s_reg.pin_data; // RULE12
    s_next.dim = s_reg.dim_en & s_reg.gpio_s2[0]; // RULE10 RULE11
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '{state: ibgc_pkg::DEV_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
                 sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1, bl_ctl: `IBGC_RST_BL,
                 dir: `IBGC_RST_PIN, pin_data: `IBGC_RST_PIN, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // open drain: only ever pulls low
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = s_reg.sda_oe;
  assign primary_drive = s_reg.drive_p;
  assign secondary_drive = s_reg.drive_s;
  assign gpio_out = s_reg.gpio_out;
  assign gpio_oe = s_reg.gpio_oe;
  assign dim_level = s_reg.dim;
  assign bus_busy = s_reg.busy;

endmodule : ibgc_device

// File: hw/ibgc_host.sv
// controller end: register-commanded two-wire master for one register write or read
`timescale 1ns/1ps
`include "ibgc_map.svh"

module ibgc_host (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link to the device
  ibgc_link_if.host link,
  // software register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);

  ibgc_pkg::ibgc_host_regs_type s_reg;
  ibgc_pkg::ibgc_host_regs_type s_next;

  logic qtick;
  logic elem_done;
  logic [2:0] seq_n;

  // element kind of each sequence slot; read inserts a repeated start
  function automatic ibgc_pkg::ibgc_host_state_type ibgc_kind(input logic [2:0] seq,
                                                             input logic is_read);
    if (seq == 3'h0 || (is_read && seq == 3'h3)) begin
      ibgc_kind = ibgc_pkg::HOST_START;
    end else if ((is_read && seq == 3'h6) || (!is_read && seq == 3'h4)) begin
      ibgc_kind = ibgc_pkg::HOST_STOP;
    end else begin
      ibgc_kind = ibgc_pkg::HOST_BIT;
    end
  endfunction : ibgc_kind

  function automatic logic [7:0] ibgc_byte(input ibgc_pkg::ibgc_host_regs_type r,
                                           input logic [2:0] seq);
    case (seq)
      3'h1: ibgc_byte = {`IBGC_DEV_ADDR, `IBGC_DIR_WRITE}; // RULE19
      3'h2: ibgc_byte = r.target; // RULE20
      3'h3: ibgc_byte = r.wdata; // RULE20
      3'h4: ibgc_byte = {`IBGC_DEV_ADDR, `IBGC_DIR_READ}; // RULE19 RULE22
      default: ibgc_byte = `IBGC_BYTE_FREE;
    endcase
  endfunction : ibgc_byte

  always_comb begin
    s_next = s_reg;
    s_next.sda_s1 = link.sda;
    s_next.sda_s2 = s_reg.sda_s1;
    qtick = s_reg.qcnt == `IBGC_QUARTER_CYC;
    elem_done = qtick && s_reg.q == 2'h3;
    seq_n = s_reg.seq + 3'h1;
    s_next.qcnt = qtick ? 4'h0 : s_reg.qcnt + 4'h1;
    if (qtick) begin
      s_next.q = s_reg.q + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // quarters: 0 clock low, 1 data change, 2 clock high, 3 hold and sample
    case (s_reg.state)
      ibgc_pkg::HOST_IDLE: begin
        s_next.qcnt = 4'h0;
        s_next.q = 2'h0;
        if (wr && addr == `IBGC_HREG_GO && (wdata[`IBGC_GO_WRITE] || wdata[`IBGC_GO_READ])) begin
          s_next.is_read = wdata[`IBGC_GO_READ];
          s_next.seq = 3'h0;
          s_next.nack = 1'b0;
          s_next.busy = 1'b1;
          s_next.state = ibgc_pkg::HOST_START;
        end
      end
      ibgc_pkg::HOST_START: begin
        if (qtick && s_reg.q == 2'h0) s_next.scl = 1'b0;
        if (qtick && s_reg.q == 2'h1) s_next.sda_oe = 1'b0;
        if (qtick && s_reg.q == 2'h2) s_next.scl = 1'b1;
        if (qtick && s_reg.q == 2'h3) s_next.sda_oe = 1'b1; // RULE15
      end
      ibgc_pkg::HOST_BIT: begin
        if (qtick && s_reg.q == 2'h0) s_next.scl = 1'b0;
        if (qtick && s_reg.q == 2'h1) begin
          // acknowledge slot: release, which is also the nack after read data
          s_next.sda_oe = (s_reg.bitn < 4'h8) ? ~s_reg.tx[3'(4'h7 - s_reg.bitn)] : 1'b0; // RULE14 RULE17 RULE24
        end
        if (qtick && s_reg.q == 2'h2) s_next.scl = 1'b1;
        if (elem_done) begin
          s_next.bitn = s_reg.bitn + 4'h1;
          if (s_reg.bitn < 4'h8) begin
            s_next.rx = {s_reg.rx[6:0], s_reg.sda_s2};
          end else if (s_reg.is_read && s_reg.seq == 3'h5) begin
            s_next.rdv = s_reg.rx;
          end else if (s_reg.sda_s2) begin
            s_next.nack = 1'b1; // RULE18
          end
        end
      end
      ibgc_pkg::HOST_STOP: begin
        if (qtick && s_reg.q == 2'h0) s_next.scl = 1'b0;
        if (qtick && s_reg.q == 2'h1) s_next.sda_oe = 1'b1;
        if (qtick && s_reg.q == 2'h2) s_next.scl = 1'b1;
        if (qtick && s_reg.q == 2'h3) s_next.sda_oe = 1'b0; // RULE15
      end
      default: s_next.state = ibgc_pkg::HOST_IDLE;
    endcase

    // advance to the next element; a refused byte ends the transfer with stop
    if (elem_done && s_reg.state != ibgc_pkg::HOST_IDLE &&
        (s_reg.state != ibgc_pkg::HOST_BIT || s_reg.bitn == 4'h8)) begin
      s_next.bitn = 4'h0;
      if (s_reg.state == ibgc_pkg::HOST_STOP) begin
        s_next.state = ibgc_pkg::HOST_IDLE;
        s_next.busy = 1'b0;
      end else if (s_next.nack) begin
        s_next.state = ibgc_pkg::HOST_STOP;
      end else begin
        s_next.seq = seq_n;
        s_next.state = ibgc_kind(seq_n, s_reg.is_read); // RULE22
        s_next.tx = ibgc_byte(s_reg, seq_n);
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    if (wr && addr == `IBGC_HREG_TARGET) s_next.target = wdata;
    if (wr && addr == `IBGC_HREG_WDATA) s_next.wdata = wdata;
    s_next.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `IBGC_HREG_TARGET: s_next.rdata = s_reg.target;
        `IBGC_HREG_WDATA: s_next.rdata = s_reg.wdata;
        `IBGC_HREG_STATUS: s_next.rdata = {6'h00, s_reg.nack, s_reg.busy};
        `IBGC_HREG_RDATA: s_next.rdata = s_reg.rdv;
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '{state: ibgc_pkg::HOST_IDLE, scl: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.scl = s_reg.scl;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = s_reg.sda_oe;
  assign rdata = s_reg.rdata;

endmodule : ibgc_host

// File: sim/ibgc_chk.sv
// concurrent checks on the two-wire link between the controller and device ends
`timescale 1ns/1ps

module ibgc_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link wires
  input wire logic scl,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////
  sequence start_seq;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_seq;
    scl && $past(scl) && $rose(sda);
  endsequence

  //////////////////////////////////////////////////////////////
  // open drain: a high level comes only from the pull-up
  drain_only_a: assert property (!host_sda_out && !dev_sda_out)
    else $error("sda driven high");
  dev_change_low_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("device moved sda with scl high");
  dev_hold_a: assert property (dev_sda_oe && $rose(scl) |=> dev_sda_oe[*8])
    else $error("device let go during scl high");
  host_hold_a: assert property ($rose(scl) |=> $stable(host_sda_oe)[*8])
    else $error("host moved sda early in scl high");
  scl_high_a: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  scl_low_a: assert property ($fell(scl) |-> (!scl)[*8] ##[1:20] scl)
    else $error("scl low phase out of range");
  start_quiet_a: assert property (start_seq |=> (!dev_sda_oe)[*8])
    else $error("device drove sda after start");
  stop_free_a: assert property (stop_seq |=> (!dev_sda_oe && !host_sda_oe)[*2])
    else $error("sda held after stop");
endmodule : ibgc_chk

// File: sim/tb.sv
// self-checking bench: controller end talks to device end over the link
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end

module tb;
  logic clock;
  logic rst;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [2:0] gpio_in;
  logic [7:0] primary_drive;
  logic [7:0] secondary_drive;
  logic [2:0] gpio_out;
  logic [2:0] gpio_oe;
  logic dim_level;
  logic bus_busy;
  logic seen_busy;
  int error_cnt;
  int check_count;
  int cyc = 0;

  ibgc_link_if link ();
  // short fade steps keep full ramps within a few thousand cycles
  ibgc_device #(.FADE_SLOW_CYC(20), .FADE_FAST_CYC(10)) ibgc_device_inst (
    .clock(clock), .rst(rst), .link(link), .primary_drive(primary_drive),
    .secondary_drive(secondary_drive), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .dim_level(dim_level), .bus_busy(bus_busy));
  ibgc_host ibgc_host_inst (.clock(clock), .rst(rst), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ibgc_chk ibgc_chk_inst (.clock(clock), .rst(rst), .scl(link.scl),
    .host_sda_out(link.host_sda_out), .host_sda_oe(link.host_sda_oe),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // polls status; a device that never acknowledges shows up as nack
  task automatic wait_idle();
    logic [7:0] s;
    s = 8'h01;
    for (int n = 0; n < 2000 && s[0] !== 1'b0; n++) begin
      reg_rd(3'h3, s);
      if (bus_busy === 1'b1) seen_busy = 1'b1;
    end
    `CHK(s[1:0], 2'b00)
  endtask : wait_idle

  task automatic dev_wr(input logic [7:0] r, input logic [7:0] d);
    reg_wr(3'h0, r);
    reg_wr(3'h1, d);
    reg_wr(3'h2, 8'h01);
    wait_idle();
  endtask : dev_wr

  task automatic dev_rd(input logic [7:0] r, output logic [7:0] d);
    reg_wr(3'h0, r);
    reg_wr(3'h2, 8'h02);
    wait_idle();
    reg_rd(3'h4, d);
  endtask : dev_rd

  // code lands mid-transfer, so roughly one bit time of the ramp is already gone
  task automatic ramp(input logic sec, input logic [7:0] tgt, input int step, input int dl);
    int n;
    for (n = 0; n < 3000 && (sec ? secondary_drive : primary_drive) !== tgt; n++) begin
      @(posedge clock);
    end
    `CHK(n <= step * dl && n >= step * dl - 120, 1'b1)
  endtask : ramp

  //////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] d;
    dev_wr(8'h05, 8'ha5);
    dev_rd(8'h05, d);
    `CHK(d, 8'ha5)
    dev_wr(8'h04, 8'hff);
    dev_rd(8'h04, d);
    `CHK(d, 8'hff)
    dev_rd(8'h10, d);
    `CHK(d, 8'h00)
    `CHK(seen_busy, 1'b1)
    `CHK(bus_busy, 1'b0)
  endtask : t_regs

  task automatic t_sinks();
    dev_wr(8'h03, 8'h02);
    `CHK(primary_drive, 8'hff)
    `CHK(secondary_drive, 8'h00)
    dev_wr(8'h03, 8'h03);
    `CHK(secondary_drive, 8'ha5)
    dev_wr(8'h03, 8'h07);
    `CHK(secondary_drive, 8'hff)
  endtask : t_sinks

  task automatic t_fade();
    dev_wr(8'h03, 8'h03);
    dev_wr(8'h04, 8'h00);
    `CHK(primary_drive, 8'h00)
    dev_wr(8'h03, 8'h2b);
    dev_wr(8'h04, 8'h40);
    ramp(1'b0, 8'h40, 10, 64);
    dev_wr(8'h03, 8'h0b);
    dev_wr(8'h04, 8'h00);
    ramp(1'b0, 8'h00, 20, 64);
    dev_wr(8'h03, 8'h2b);
    dev_wr(8'h04, 8'h10);
    ramp(1'b0, 8'h10, 10, 16);
    dev_wr(8'h03, 8'h3b);
    dev_wr(8'h05, 8'h85);
    ramp(1'b1, 8'h85, 10, 32);
    `CHK(primary_drive, 8'h10)
    dev_wr(8'h03, 8'h2f);
    dev_wr(8'h04, 8'h30);
    // a few steps in: secondary must be on its way up, not jumped and not on its own code
    `CHK(secondary_drive > 8'h10 && secondary_drive < 8'h30, 1'b1)
    ramp(1'b1, 8'h30, 10, 32);
    `CHK(primary_drive, 8'h30)
  endtask : t_fade

  task automatic t_pins();
    logic [7:0] d;
    dev_wr(8'h06, 8'h07);
    dev_wr(8'h07, 8'h05);
    `CHK(gpio_out, 3'h5)
    `CHK(gpio_oe, 3'h7)
    @(posedge clock);
    gpio_in <= 3'h2;
    dev_rd(8'h07, d);
    `CHK(d, 8'h02)
    @(posedge clock);
    gpio_in <= 3'h1;
    dev_wr(8'h06, 8'h13);
    `CHK(gpio_oe, 3'h2)
    `CHK(dim_level, 1'b1)
    dev_rd(8'h06, d);
    `CHK(d, 8'h13)
    @(posedge clock);
    gpio_in <= 3'h6;
    dev_rd(8'h07, d);
    `CHK(d, 8'h06)
    `CHK(dim_level, 1'b0)
  endtask : t_pins

  initial begin
    rst = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    gpio_in = 3'h0;
    seen_busy = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_sinks();
    t_fade();
    t_pins();
    end_sim();
  end
endmodule : tb
